// file: bsram_pkg.sv
// Shared constants for the burst-of-four synchronous SRAM link.
// Assumes both ends run on one system clock rate and sample each other's pins.
package bsram_pkg;
  // ---------------------------------------------------------------
  // Data organisation
  // ---------------------------------------------------------------
  localparam int DW = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BEATS = 4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int LINK_NS = 800;
  localparam int HALF_CYC = LINK_NS / (2 * CLK_NS);
  localparam int TIE_NS = 1600;
  localparam int TIE_CYC = (TIE_NS + CLK_NS - 1) / CLK_NS;
  // Half-edge counts after the command edge
  localparam int RD_FIRST = 3;
  localparam int RD_LAST = RD_FIRST + BEATS - 1;
  localparam int RD_END = RD_LAST + 1;
  localparam int WR_FIRST = 6;
  localparam int WR_LAST = WR_FIRST + BEATS - 1;
  localparam int CAP_FIRST = RD_FIRST + 2;
  localparam int CAP_LAST = CAP_FIRST + BEATS - 1;
  // Least command spacing in link cycles, by previous then next kind
  localparam int GAP_RR = 2;
  localparam int GAP_RW = 1;
  localparam int GAP_WW = 2;
  localparam int GAP_WR = 4;
  localparam int GAP_MAX = 7;
endpackage : bsram_pkg

// file: bsram_if.sv
// Pin bundle between the SRAM device model and its memory controller.
// Assumes each end drives its own data lanes with an enable; the wire is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface bsram_if #(parameter int AW = 22);
  logic main_clock_true;
  logic main_clock_comp;
  logic output_clock_true;
  logic output_clock_comp;
  logic load_new_address_n;
  logic read_not_write;
  logic burst_addr_bit0;
  logic burst_addr_bit1;
  logic [AW-3:0] addr_upper;
  logic byte_lane0_write_n;
  logic byte_lane1_write_n;
  logic [17:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [17:0] dev_dq_o;
  logic dev_dq_oe;
  logic [17:0] dq;
  // Device wins a momentary overlap at turnaround; undriven bus reads zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 18'h0);
  modport dev (
    input main_clock_true, main_clock_comp, output_clock_true, output_clock_comp,
    input load_new_address_n, read_not_write, burst_addr_bit0, burst_addr_bit1, addr_upper,
    input byte_lane0_write_n, byte_lane1_write_n, dq,
    output dev_dq_o, dev_dq_oe
  );
  modport ctl (
    output main_clock_true, main_clock_comp, output_clock_true, output_clock_comp,
    output load_new_address_n, read_not_write, burst_addr_bit0, burst_addr_bit1, addr_upper,
    output byte_lane0_write_n, byte_lane1_write_n, ctl_dq_o, ctl_dq_oe,
    input dq
  );
endinterface : bsram_if
`default_nettype wire

// file: bsram_dev.sv
// SRAM device end: command decode, burst ordering, write buffers, array and read drivers.
// Assumes link pins toggle far slower than clock; all are sampled through two flops.
`timescale 1ns/1ns
`default_nettype none
module bsram_dev
  import bsram_pkg::*;
#(
  parameter int AW = 22,
  parameter int NS = 6
) (
  input wire logic clock,
  input wire logic rst_b,
  bsram_if.dev lnk,
  output logic single_clock_mode,
  output logic burst_active
);
  localparam int SW = 4 + 2 + AW + 2 + DW;
  localparam int IW = $clog2(NS);
  // Idle pin levels, so leaving reset shows no false clock edge
  localparam logic [SW-1:0] SYNC_IDLE = {4'b0101, 2'b11, {AW{1'b0}}, 2'b11, {DW{1'b0}}};

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [3:0] ck_prev_q;
  logic [3:0] ck_rise;
  logic ld_n;
  logic rnw;
  logic [AW-1:0] cmd_addr;
  logic [1:0] lane_n;
  logic [DW-1:0] din;
  logic tied_q;
  logic [7:0] tie_cnt_q;
  logic main_edge;
  logic out_edge;
  logic cmd_take;

  assign raw = {lnk.main_clock_true, lnk.main_clock_comp, lnk.output_clock_true,
                lnk.output_clock_comp, lnk.load_new_address_n, lnk.read_not_write,
                lnk.addr_upper, lnk.burst_addr_bit1, lnk.burst_addr_bit0,
                lnk.byte_lane1_write_n, lnk.byte_lane0_write_n, lnk.dq};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      ck_prev_q <= 4'h5;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      ck_prev_q <= s2_q[SW-1 -: 4];
    end
  end

  assign ck_rise = s2_q[SW-1 -: 4] & ~ck_prev_q;
  assign {ld_n, rnw, cmd_addr, lane_n, din} = s2_q[SW-5:0];
  assign main_edge = ck_rise[3] | ck_rise[2];
  assign out_edge = tied_q ? main_edge : (ck_rise[1] | ck_rise[0]);
  assign cmd_take = ck_rise[3] & ~ld_n;

  // ---------------------------------------------------------------
  // Single-clock detection
  // ---------------------------------------------------------------
  // Longer than a link period, so normal complementary clocks never qualify
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tie_cnt_q <= 8'h0;
      tied_q <= 1'b0;
    end else if (!(s2_q[SW-3] && s2_q[SW-4])) begin
      tie_cnt_q <= 8'h0;
      tied_q <= 1'b0;
    end else if (tie_cnt_q == 8'(TIE_CYC - 1)) begin
      tied_q <= 1'b1;
    end else begin
      tie_cnt_q <= tie_cnt_q + 8'h1;
    end
  end

  // ---------------------------------------------------------------
  // Burst trackers
  // ---------------------------------------------------------------
  logic [NS-1:0] sv_q;
  logic [NS-1:0] sw_q;
  logic [3:0] sc_q [NS];
  logic [AW-1:0] sa_q [NS];
  logic free_ok;
  logic [IW-1:0] free_ix;
  logic rd_hit;
  logic [1:0] rd_beat;
  logic [AW-1:0] rd_base;
  logic wr_hit;
  logic [1:0] wr_beat;
  logic [AW-1:0] wr_base;

  function automatic logic [AW-1:0] waddr(input logic [AW-1:0] b, input logic [1:0] k);
    return {b[AW-1:2], b[1:0] + k};
  endfunction : waddr

  always_comb begin
    free_ok = 1'b0;
    free_ix = '0;
    rd_hit = 1'b0;
    rd_beat = 2'h0;
    rd_base = '0;
    wr_hit = 1'b0;
    wr_beat = 2'h0;
    wr_base = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!sv_q[i]) begin
        free_ok = 1'b1;
        free_ix = IW'(i);
      end else if (!sw_q[i]) begin
        if (out_edge && (sc_q[i] + 4'h1) >= 4'(RD_FIRST) && (sc_q[i] + 4'h1) <= 4'(RD_LAST)) begin
          rd_hit = 1'b1;
          rd_beat = 2'(sc_q[i] + 4'h1 - 4'(RD_FIRST));
          rd_base = sa_q[i];
        end
      end else if (main_edge && (sc_q[i] + 4'h1) >= 4'(WR_FIRST) && (sc_q[i] + 4'h1) <= 4'(WR_LAST)) begin
        wr_hit = 1'b1;
        wr_beat = 2'(sc_q[i] + 4'h1 - 4'(WR_FIRST));
        wr_base = sa_q[i];
      end
    end
  end

  // Reads count output-pair edges (main-pair edges in single-clock mode), writes count main-pair edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sv_q <= '0;
      sw_q <= '0;
      for (int i = 0; i < NS; i++) begin
        sc_q[i] <= 4'h0;
        sa_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (sv_q[i] && (sw_q[i] ? main_edge : out_edge)) begin
          sc_q[i] <= sc_q[i] + 4'h1;
          if ((sc_q[i] + 4'h1) == (sw_q[i] ? 4'(WR_LAST) : 4'(RD_END))) begin
            sv_q[i] <= 1'b0;
          end
        end
      end
      // A load-high edge adds nothing and disturbs no running burst
      if (cmd_take && free_ok) begin
        sv_q[free_ix] <= 1'b1;
        sw_q[free_ix] <= ~rnw;
        sc_q[free_ix] <= 4'h0;
        sa_q[free_ix] <= cmd_addr;
      end
    end
  end

  assign burst_active = |sv_q;
  assign single_clock_mode = tied_q;

  // ---------------------------------------------------------------
  // Write beat collection and buffers
  // ---------------------------------------------------------------
  logic [DW-1:0] wd_q [BEATS];
  logic [LANES-1:0] wl_q [BEATS];
  logic push;
  logic [1:0] bv_q;
  logic [AW-1:0] ba_q [2];
  logic [DW-1:0] bd_q [2][BEATS];
  logic [LANES-1:0] bl_q [2][BEATS];
  logic [DW-1:0] mem [0:2**AW-1];

  assign push = wr_hit && (wr_beat == 2'(BEATS - 1));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < BEATS; k++) begin
        wd_q[k] <= '0;
        wl_q[k] <= '0;
      end
    end else if (wr_hit) begin
      wd_q[wr_beat] <= din;
      wl_q[wr_beat] <= ~lane_n;
    end
  end

  // Slot 0 newest; the burst pushed out of slot 1 goes to the array
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bv_q <= 2'h0;
      for (int e = 0; e < 2; e++) begin
        ba_q[e] <= '0;
        for (int k = 0; k < BEATS; k++) begin
          bd_q[e][k] <= '0;
          bl_q[e][k] <= '0;
        end
      end
    end else if (push) begin
      bv_q <= {bv_q[0], 1'b1};
      ba_q[1] <= ba_q[0];
      bd_q[1] <= bd_q[0];
      bl_q[1] <= bl_q[0];
      ba_q[0] <= wr_base;
      for (int k = 0; k < BEATS - 1; k++) begin
        bd_q[0][k] <= wd_q[k];
        bl_q[0][k] <= wl_q[k];
      end
      bd_q[0][BEATS-1] <= din;
      bl_q[0][BEATS-1] <= ~lane_n;
    end
  end

  always_ff @(posedge clock) begin
    if (push && bv_q[1]) begin
      for (int k = 0; k < BEATS; k++) begin
        for (int l = 0; l < LANES; l++) begin
          if (bl_q[1][k][l]) begin
            mem[waddr(ba_q[1], 2'(k))][l*LANE_W +: LANE_W] <= bd_q[1][k][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // Array word overlaid by older then newer buffered bursts
  function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] w);
    logic [DW-1:0] v;
    v = mem[w];
    for (int e = 1; e >= 0; e--) begin
      for (int k = 0; k < BEATS; k++) begin
        for (int l = 0; l < LANES; l++) begin
          if (bv_q[e] && waddr(ba_q[e], 2'(k)) == w && bl_q[e][k][l]) begin
            v[l*LANE_W +: LANE_W] = bd_q[e][k][l*LANE_W +: LANE_W];
          end
        end
      end
    end
    return v;
  endfunction : rd_word

  // ---------------------------------------------------------------
  // Read drivers
  // ---------------------------------------------------------------
  logic [DW-1:0] dq_q;
  logic oe_q;

  // Nothing moves without an output edge, so a stopped clock freezes the pins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dq_q <= '0;
      oe_q <= 1'b0;
    end else if (out_edge) begin
      oe_q <= rd_hit;
      if (rd_hit) begin
        dq_q <= rd_word(waddr(rd_base, rd_beat));
      end
    end
  end

  assign lnk.dev_dq_o = dq_q;
  assign lnk.dev_dq_oe = oe_q;
endmodule : bsram_dev
`default_nettype wire

// file: bsram_ctl.sv
// Memory controller end: makes the link clocks, issues commands, streams write data,
// collects read bursts. Assumes the device answers with the fixed edge latencies.
`timescale 1ns/1ns
`default_nettype none
module bsram_ctl
  import bsram_pkg::*;
#(
  parameter int AW = 22,
  parameter int HALF = HALF_CYC,
  parameter int NSL = 3,
  parameter bit SINGLE = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  bsram_if.ctl lnk,
  input wire logic clock_stop,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [BEATS*DW-1:0] cmd_wdata,
  input wire logic [BEATS*LANES-1:0] cmd_lane_n,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [BEATS*DW-1:0] rd_data,
  output logic link_idle
);
  // ---------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------
  logic [7:0] hc_q;
  logic kt_q;
  logic run;
  logic tick;
  logic mid;
  logic pre_comp;
  logic ld_n_q;
  logic [NSL-1:0] wv_q;
  logic [NSL-1:0] rv_q;

  assign link_idle = ld_n_q && !(|wv_q) && !(|rv_q);
  assign run = !(clock_stop && link_idle);
  assign tick = run && (hc_q == 8'(HALF - 1));
  assign mid = run && (hc_q == 8'(HALF / 2));
  assign pre_comp = tick && kt_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hc_q <= 8'h0;
      kt_q <= 1'b0;
    end else if (tick) begin
      hc_q <= 8'h0;
      kt_q <= ~kt_q;
    end else if (run) begin
      hc_q <= hc_q + 8'h1;
    end
  end

  assign lnk.main_clock_true = kt_q;
  assign lnk.main_clock_comp = ~kt_q;
  assign lnk.output_clock_true = SINGLE ? 1'b1 : kt_q;
  assign lnk.output_clock_comp = SINGLE ? 1'b1 : ~kt_q;

  // ---------------------------------------------------------------
  // Command issue
  // ---------------------------------------------------------------
  logic [2:0] lc_q;
  logic last_w_q;
  logic rnw_q;
  logic [AW-1:0] addr_q;
  logic [2:0] need;
  logic wok;
  logic rok;
  logic accept;
  logic [$clog2(NSL)-1:0] wfree;
  logic [$clog2(NSL)-1:0] rfree;

  always_comb begin
    wok = 1'b0;
    rok = 1'b0;
    wfree = '0;
    rfree = '0;
    for (int i = NSL - 1; i >= 0; i--) begin
      if (!wv_q[i]) begin
        wok = 1'b1;
        wfree = ($clog2(NSL))'(i);
      end
      if (!rv_q[i]) begin
        rok = 1'b1;
        rfree = ($clog2(NSL))'(i);
      end
    end
    // Read after write waits until the write data has left the bus
    if (last_w_q) begin
      need = cmd_write ? 3'(GAP_WW) : 3'(GAP_WR);
    end else begin
      need = cmd_write ? 3'(GAP_RW) : 3'(GAP_RR);
    end
  end

  assign cmd_ready = pre_comp && !clock_stop && lc_q >= need && (cmd_write ? wok : rok);
  assign accept = cmd_valid && cmd_ready;

  // Command changes on the comp edge, so it is stable at the true edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ld_n_q <= 1'b1;
      rnw_q <= 1'b1;
      addr_q <= '0;
      lc_q <= 3'(GAP_MAX);
      last_w_q <= 1'b0;
    end else if (pre_comp) begin
      ld_n_q <= ~accept;
      rnw_q <= ~(accept && cmd_write);
      if (accept) begin
        addr_q <= cmd_addr;
        lc_q <= 3'h1;
        last_w_q <= cmd_write;
      end else if (lc_q != 3'(GAP_MAX)) begin
        lc_q <= lc_q + 3'h1;
      end
    end
  end

  assign lnk.load_new_address_n = ld_n_q;
  assign lnk.read_not_write = rnw_q;
  assign lnk.burst_addr_bit0 = addr_q[0];
  assign lnk.burst_addr_bit1 = addr_q[1];
  assign lnk.addr_upper = addr_q[AW-1:2];

  // ---------------------------------------------------------------
  // Write data stream
  // ---------------------------------------------------------------
  logic [3:0] wc_q [NSL];
  logic [BEATS*DW-1:0] wdat_q [NSL];
  logic [BEATS*LANES-1:0] wlan_q [NSL];
  logic [DW-1:0] dq_q;
  logic oe_q;
  logic [1:0] lanes_n_q;

  // Data moves mid-half so it is stable around each capture edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wv_q <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
      lanes_n_q <= 2'h3;
      for (int i = 0; i < NSL; i++) begin
        wc_q[i] <= 4'h0;
        wdat_q[i] <= '0;
        wlan_q[i] <= '0;
      end
    end else begin
      if (mid) begin
        oe_q <= 1'b0;
        for (int i = 0; i < NSL; i++) begin
          if (wv_q[i] && wc_q[i] >= 4'(WR_FIRST) && wc_q[i] <= 4'(WR_LAST)) begin
            dq_q <= wdat_q[i][(wc_q[i] - 4'(WR_FIRST))*DW +: DW];
            lanes_n_q <= wlan_q[i][(wc_q[i] - 4'(WR_FIRST))*LANES +: LANES];
            oe_q <= 1'b1;
          end
          if (wv_q[i] && wc_q[i] == 4'(WR_LAST + 1)) begin
            wv_q[i] <= 1'b0;
          end
        end
      end
      for (int i = 0; i < NSL; i++) begin
        if (wv_q[i] && tick) begin
          wc_q[i] <= wc_q[i] + 4'h1;
        end
      end
      if (accept && cmd_write) begin
        wv_q[wfree] <= 1'b1;
        wc_q[wfree] <= 4'h0;
        wdat_q[wfree] <= cmd_wdata;
        wlan_q[wfree] <= cmd_lane_n;
      end
    end
  end

  assign lnk.ctl_dq_o = dq_q;
  assign lnk.ctl_dq_oe = oe_q;
  assign lnk.byte_lane0_write_n = lanes_n_q[0];
  assign lnk.byte_lane1_write_n = lanes_n_q[1];

  // ---------------------------------------------------------------
  // Read collection
  // ---------------------------------------------------------------
  logic [DW-1:0] ds1_q;
  logic [DW-1:0] ds2_q;
  logic [3:0] rc_q [NSL];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ds1_q <= '0;
      ds2_q <= '0;
    end else begin
      ds1_q <= lnk.dq;
      ds2_q <= ds1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rv_q <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      for (int i = 0; i < NSL; i++) begin
        rc_q[i] <= 4'h0;
      end
    end else begin
      rd_valid <= 1'b0;
      for (int i = 0; i < NSL; i++) begin
        if (rv_q[i] && tick) begin
          rc_q[i] <= rc_q[i] + 4'h1;
        end
        if (rv_q[i] && mid && rc_q[i] >= 4'(CAP_FIRST) && rc_q[i] <= 4'(CAP_LAST)) begin
          rd_data[(rc_q[i] - 4'(CAP_FIRST))*DW +: DW] <= ds2_q;
          if (rc_q[i] == 4'(CAP_LAST)) begin
            rv_q[i] <= 1'b0;
            rd_valid <= 1'b1;
          end
        end
      end
      if (accept && !cmd_write) begin
        rv_q[rfree] <= 1'b1;
        rc_q[rfree] <= 4'h0;
      end
    end
  end
endmodule : bsram_ctl
`default_nettype wire

// file: bsram_checker.sv
// Pin-level timing checks for the burst SRAM link.
// Assumes the system clock samples the link pins and HALF is four clocks.
`timescale 1ns/1ns
`default_nettype none
module bsram_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic main_clock_true,
  input wire logic main_clock_comp,
  input wire logic output_clock_true,
  input wire logic output_clock_comp,
  input wire logic load_new_address_n,
  input wire logic read_not_write,
  input wire logic ctl_dq_oe,
  input wire logic [17:0] dev_dq_o,
  input wire logic dev_dq_oe
);
  // ------------------------------
  // Command edge and age tracking
  // ------------------------------
  logic mt_q;
  logic [7:0] rd_age_q;
  logic [7:0] wr_age_q;
  logic [7:0] wr_prev_q;
  logic [5:0] still_q;
  logic cmd_rd;
  logic cmd_wr;
  assign cmd_rd = main_clock_true && !mt_q && !load_new_address_n && read_not_write;
  assign cmd_wr = main_clock_true && !mt_q && !load_new_address_n && !read_not_write;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mt_q <= 1'b0;
    end else begin
      mt_q <= main_clock_true;
    end
  end
  // Ages saturate so a long idle never wraps back into a window
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_age_q <= 8'hff;
      wr_age_q <= 8'hff;
      wr_prev_q <= 8'hff;
    end else begin
      rd_age_q <= cmd_rd ? 8'h00 : rd_age_q + {7'h0, rd_age_q != 8'hff};
      wr_age_q <= cmd_wr ? 8'h00 : wr_age_q + {7'h0, wr_age_q != 8'hff};
      // A newer write may be issued before the older burst's data ends
      wr_prev_q <= cmd_wr ? wr_age_q + {7'h0, wr_age_q != 8'hff} : wr_prev_q + {7'h0, wr_prev_q != 8'hff};
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      still_q <= 6'h00;
    end else begin
      still_q <= (main_clock_true != mt_q) ? 6'h00 : still_q + {5'h0, still_q != 6'h3f};
    end
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_pair_clk: assert property (main_clock_comp == !main_clock_true)
    else $error("main clock pair not complementary");
  a_out_clk: assert property (output_clock_true == main_clock_true && output_clock_comp == main_clock_comp)
    else $error("output clock pair differs from main pair");
  a_load_len: assert property ($fell(load_new_address_n) |-> !load_new_address_n [*6])
    else $error("command load too short");
  a_nop_read: assert property (load_new_address_n |-> read_not_write)
    else $error("write level outside a command");
  a_rd_first: assert property ($rose(dev_dq_oe) |-> rd_age_q inside {[10:18]})
    else $error("read drivers on at wrong time");
  a_rd_window: assert property (rd_age_q inside {[18:26]} |-> dev_dq_oe)
    else $error("read beat missing");
  a_rd_release: assert property (rd_age_q > 8'd36 |-> !dev_dq_oe)
    else $error("drivers left on after burst");
  a_wr_start: assert property (cmd_wr |-> ##[18:26] ctl_dq_oe)
    else $error("write data not driven in time");
  a_wr_end: assert property ($fell(ctl_dq_oe) |-> (wr_age_q inside {[32:42]} || wr_prev_q inside {[32:42]}))
    else $error("write data released at wrong time");
  a_stop_drain: assert property (still_q == 6'd10 |-> rd_age_q > 8'd30 && wr_age_q > 8'd38)
    else $error("clocks stopped with burst pending");
  a_stop_hold: assert property (still_q > 6'd10 |-> $stable(dev_dq_oe) && $stable(dev_dq_o))
    else $error("data pins moved while stopped");
  c_read: cover property (cmd_rd);
  c_write: cover property (cmd_wr);
  c_stop: cover property (still_q == 6'd20);
endmodule : bsram_checker
`default_nettype wire

// file: tb_top.sv
// Self-checking bench: controller and device joined by the link interface.
// Assumes a 100 ns system clock and an 8-bit word address.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import bsram_pkg::*;
;
  logic clock, rst_b, clock_stop, cmd_valid, cmd_write, cmd_ready;
  logic rd_valid, link_idle, single_mode, busy;
  logic [7:0] cmd_addr, cmd_lane_n;
  logic [71:0] cmd_wdata, rd_data;
  logic [17:0] mem [0:255];
  int n_errors, checks, cycles;
  bsram_if #(.AW(8)) lnk ();
  bsram_dev #(.AW(8)) i_bsram_dev (.clock(clock), .rst_b(rst_b), .lnk(lnk.dev),
    .single_clock_mode(single_mode), .burst_active(busy));
  bsram_ctl #(.AW(8)) i_bsram_ctl (.clock(clock), .rst_b(rst_b), .lnk(lnk.ctl),
    .clock_stop(clock_stop), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_lane_n(cmd_lane_n), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .link_idle(link_idle));
  bsram_checker i_bsram_checker (.clock(clock), .rst_b(rst_b),
    .main_clock_true(lnk.main_clock_true), .main_clock_comp(lnk.main_clock_comp),
    .output_clock_true(lnk.output_clock_true), .output_clock_comp(lnk.output_clock_comp),
    .load_new_address_n(lnk.load_new_address_n), .read_not_write(lnk.read_not_write),
    .ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq_o(lnk.dev_dq_o), .dev_dq_oe(lnk.dev_dq_oe));
  // ------------------------------
  // Helpers
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] idx(input logic [7:0] a, input int k);
    return {a[7:2], 2'(a[1:0] + k)};
  endfunction : idx
  function automatic logic [71:0] exp_rd(input logic [7:0] a);
    logic [71:0] r;
    for (int k = 0; k < BEATS; k++) r[k*DW +: DW] = mem[idx(a, k)];
    return r;
  endfunction : exp_rd
  function automatic logic [71:0] rnd();
    logic [95:0] t;
    t = {$urandom, $urandom, $urandom};
    return t[71:0];
  endfunction : rnd
  // One command, held until the controller takes it; the model follows writes
  task automatic send(input logic w, input logic [7:0] a, input logic [71:0] d, input logic [7:0] ln);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_lane_n = ln;
    do begin
      @(negedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    check("cmd_ready", {71'h0, cmd_ready}, 72'h1);
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    for (int k = 0; k < BEATS && w; k++) begin
      if (!ln[2*k]) mem[idx(a, k)][8:0] = d[k*DW +: LANE_W];
      if (!ln[2*k+1]) mem[idx(a, k)][17:9] = d[k*DW+LANE_W +: LANE_W];
    end
  endtask : send
  task automatic get(input logic [71:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rd_valid !== 1'b1 && n < 300);
    check("rd_valid", {71'h0, rd_valid}, 72'h1);
    check("rd_data", rd_data, exp);
  endtask : get
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [71:0] e;
    logic [71:0] f;
    logic mt;
    logic [17:0] dq;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    rst_b = 1'b0;
    clock_stop = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 72'h0;
    cmd_lane_n = 8'hff;
    void'($urandom(32'hdfe6));
    repeat (8) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 256; i += 4) send(1'b1, 8'(i), rnd(), 8'h00);
    // Every start offset, reads back to back
    for (int s = 0; s < 4; s += 2) begin
      a = {6'(s + 9), 2'(s)};
      b = {6'(s + 20), 2'(s + 1)};
      send(1'b0, a, 72'h0, 8'h00);
      send(1'b0, b, 72'h0, 8'h00);
      get(exp_rd(a));
      get(exp_rd(b));
    end
    // All four lane codes in every beat position, read from the buffers
    for (int r = 0; r < 4; r++) begin
      a = {6'(r + 40), 2'(r)};
      send(1'b1, a, rnd(), 8'({8'h1b, 8'h1b} >> (2 * r)));
      send(1'b0, a, 72'h0, 8'h00);
      get(exp_rd(a));
    end
    // Read with a write to the same place on the next command edge
    a = 8'h35;
    e = exp_rd(a);
    send(1'b0, a, 72'h0, 8'h00);
    send(1'b1, a, rnd(), 8'h00);
    get(e);
    send(1'b0, a, 72'h0, 8'h00);
    get(exp_rd(a));
    // Stop request while a read is outstanding
    a = 8'h62;
    send(1'b0, a, 72'h0, 8'h00);
    clock_stop = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    check("burst_active", {71'h0, busy}, 72'h1);
    get(exp_rd(a));
    repeat (20) @(posedge clock);
    #1;
    mt = lnk.main_clock_true;
    dq = lnk.dq;
    repeat (40) @(posedge clock);
    #1;
    check("stopped_clock", {71'h0, lnk.main_clock_true}, {71'h0, mt});
    check("stopped_dq", {54'h0, lnk.dq}, {54'h0, dq});
    check("link_idle", {71'h0, link_idle}, 72'h1);
    check("burst_active", {71'h0, busy}, 72'h0);
    clock_stop = 1'b0;
    // Random mix, often revisiting the last written burst
    b = 8'h00;
    for (int i = 0; i < 40; i++) begin
      a = ($urandom % 2) ? b : 8'($urandom);
      f = rnd();
      if ($urandom % 2) begin
        send(1'b1, a, f, 8'($urandom));
        b = a;
      end else begin
        send(1'b0, a, 72'h0, 8'h00);
        get(exp_rd(a));
      end
    end
    check("single_clock_mode", {71'h0, single_mode}, 72'h0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
